// File: hw/ieps_port.sv
// host-side parallel port link signalling: compatibility, nibble, EPP, ECP
//
// Operation
// (RQ1) compat: strobe low marks valid output data
// (RQ2) compat: no new byte while busy high
// (RQ3) compat: ack low pulse acknowledges the byte
// (RQ4) compat: decode paper empty, online, error status
// (RQ5) compat: active-low init, autofeed, select controls
// (RQ6) nibble: autofeed is host busy handshake
// (RQ7) nibble: select-in high while in 1284 mode
// (RQ8) nibble: status lines carry low then high nibble
// (RQ9) nibble: busy low, clock low, busy high, clock high
// (RQ10) EPP: strobe low for write, high read
// (RQ11) EPP: autofeed data strobe, select-in address strobe
// (RQ12) EPP: wait low starts, wait high ends strobe
// (RQ13) EPP: init resets peripheral, ack interrupts host
// (RQ14) EPP: write asserts, strobes, waits, then releases
// (RQ15) EPP: data lines are bidirectional address/data
// (RQ16) ECP: init low requests reverse, await ack
// (RQ17) ECP: error low means peripheral has data
// (RQ18) ECP forward: clock low, ack high, clock high
// (RQ19) ECP forward: host ack low marks command
// (RQ20) ECP reverse: clock low, host ack, release
// (RQ21) ECP reverse: peripheral ack low marks command
// (RQ22) synchronise every peripheral input before use
`timescale 1ns/1ps
`default_nettype none
`include "ieps_params.svh"

module ieps_port
  import ieps_pkg::*;
#(
  parameter int TIMEOUT_CYC = `IEPS_TMO_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ieps_mode_t mode,
  input wire logic init_req,
  input wire logic autofd_req,
  input wire logic select_req,
  input wire logic ecp_reverse,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_addr,
  input wire logic [7:0] req_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_cmd,
  output logic rsp_err,
  output logic paper_empty,
  output logic online,
  output logic fault,
  output logic printer_busy,
  output logic periph_req,
  output logic ack_event,
  output logic periph_intr,
  output logic [7:0] pd_out,
  output logic pd_oe_n,
  input wire logic [7:0] pd_in,
  output logic strobe_n,
  output logic autofd_n,
  output logic slctin_n,
  output logic init_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic pe,
  input wire logic slct,
  input wire logic error_n
);

  typedef struct packed {
    ieps_st_t st;
    logic [3:0] tcnt;
    logic [16:0] wdog;
    logic [7:0] data;
    logic nib_hi;
    logic ack_got;
    logic ack_prev;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_cmd;
    logic rsp_err;
    logic ack_event;
    logic periph_intr;
    logic [7:0] pd_out;
    logic pd_oe_n;
    logic strobe_n;
    logic autofd_n;
    logic slctin_n;
    logic init_n;
  } ieps_port_st_t;

  localparam logic [3:0] SETUP_CYC = 4'(`IEPS_SETUP_CYC);
  localparam logic [3:0] STB_CYC = 4'(`IEPS_STB_CYC);
  localparam logic [3:0] HOLD_CYC = 4'(`IEPS_HOLD_CYC);
  localparam logic [16:0] TMO_LAST = 17'(TIMEOUT_CYC - 1);

  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 131071) begin : g_chk_tmo
    $error("ieps_port: TIMEOUT_CYC must lie in 1..131071");
  end
  if (`IEPS_SETUP_CYC > 15 || `IEPS_STB_CYC > 15 || `IEPS_HOLD_CYC > 15) begin : g_chk_t
    $error("ieps_port: strobe timing exceeds the 4-bit counter");
  end

  ieps_port_st_t q;
  ieps_port_st_t d;
  logic [12:0] sync_out;
  logic [7:0] pd_s;
  logic ack_n_s;
  logic busy_s;
  logic pe_s;
  logic slct_s;
  logic error_n_s;
  logic ack_fall;
  logic tmo;

  ieps_sync #(
    .WIDTH(13)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({pd_in, ack_n, busy, pe, slct, error_n}),
    .dout(sync_out)
  ); // RQ22

  assign {pd_s, ack_n_s, busy_s, pe_s, slct_s, error_n_s} = sync_out;
  assign ack_fall = q.ack_prev & ~ack_n_s;
  assign tmo = (q.wdog == TMO_LAST);

  // address or data strobe choice for the EPP cycle in flight
  function automatic logic req_addr_q(ieps_port_st_t s);
    return s.rsp_cmd;
  endfunction

  // ends a transfer: one-cycle answer, strobe released, back to idle
  function automatic ieps_port_st_t finish(ieps_port_st_t s, logic err);
    ieps_port_st_t r;
    r = s;
    r.st = S_IDLE;
    r.rsp_valid = 1'b1;
    r.rsp_err = err;
    r.rsp_data = err ? 8'h00 : s.data;
    r.strobe_n = 1'b1;
    return r;
  endfunction

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.ack_event = 1'b0;
    d.periph_intr = 1'b0;
    d.ack_prev = ack_n_s;
    d.wdog = 17'(q.wdog + 17'h00001);
    if (ack_fall && mode == IEPS_COMPAT) begin
      d.ack_event = 1'b1; // RQ3
      d.ack_got = 1'b1; // RQ3
    end
    if (ack_fall && mode == IEPS_EPP) begin
      d.periph_intr = 1'b1; // RQ13
    end
    case (q.st)
      S_IDLE: begin
        d.wdog = 17'h00000;
        d.tcnt = 4'h0;
        d.strobe_n = 1'b1;
        d.rsp_cmd = 1'b0;
        d.nib_hi = 1'b0;
        case (mode)
          IEPS_COMPAT: begin
            d.autofd_n = ~autofd_req; // RQ5
            d.slctin_n = ~select_req; // RQ5
            d.init_n = ~init_req; // RQ5
            d.pd_oe_n = 1'b0; // RQ1
          end
          IEPS_NIBBLE: begin
            d.autofd_n = 1'b1; // RQ6
            d.slctin_n = 1'b1; // RQ7
            d.init_n = 1'b1; // RQ6
            d.pd_oe_n = 1'b1; // RQ7
          end
          IEPS_EPP: begin
            d.autofd_n = 1'b1;
            d.slctin_n = 1'b1;
            d.init_n = ~init_req; // RQ13
            d.pd_oe_n = 1'b1; // RQ15
          end
          default: begin
            // host ack rests low in reverse: ready for the next byte
            d.autofd_n = ~ecp_reverse; // RQ20
            d.slctin_n = 1'b1; // RQ7
            d.init_n = ~ecp_reverse; // RQ16
            d.pd_oe_n = ecp_reverse;
          end
        endcase
        if (req_valid) begin
          d.data = req_data;
          // an ack edge landing on the take edge is kept: set wins over clear
          d.ack_got = ack_fall & (mode == IEPS_COMPAT);
          case (mode)
            IEPS_COMPAT: begin
              if (req_write && !req_addr) begin
                d.st = S_CP_BUSY;
              end else begin
                d = finish(d, 1'b1);
              end
            end
            IEPS_NIBBLE: begin
              if (!req_write && !req_addr) begin
                d.data = 8'h00;
                d.autofd_n = 1'b0; // RQ9
                d.st = S_NB_LO;
              end else begin
                d = finish(d, 1'b1);
              end
            end
            IEPS_EPP: begin
              d.strobe_n = ~req_write; // RQ10
              d.pd_out = req_data; // RQ14
              d.pd_oe_n = ~req_write; // RQ15
              // the EPP cycle kind rides in rsp_cmd until the return to S_IDLE clears it
              d.rsp_cmd = req_addr;
              d.st = S_EP_LO;
            end
            default: begin
              if (req_write && !ecp_reverse) begin
                d.pd_out = req_data; // RQ18
                d.autofd_n = ~req_addr; // RQ19
                d.st = S_EF_LO;
              end else if (!req_write && !req_addr && ecp_reverse) begin
                d.st = S_ER_REV;
              end else begin
                d = finish(d, 1'b1);
              end
            end
          endcase
        end
      end
      S_CP_BUSY: begin
        // a byte is presented only once the printer lets go of busy
        if (!busy_s) begin
          d.pd_out = q.data; // RQ2
          d.tcnt = 4'h0;
          d.st = S_CP_SETUP;
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_CP_SETUP: begin
        d.tcnt = 4'(q.tcnt + 4'h1);
        if (q.tcnt == SETUP_CYC - 4'h1) begin
          d.strobe_n = 1'b0; // RQ1
          d.tcnt = 4'h0;
          d.st = S_CP_STB;
        end
      end
      S_CP_STB: begin
        d.tcnt = 4'(q.tcnt + 4'h1);
        if (q.tcnt == STB_CYC - 4'h1) begin
          d.strobe_n = 1'b1; // RQ1
          d.tcnt = 4'h0;
          d.st = S_CP_HOLD;
        end
      end
      S_CP_HOLD: begin
        d.tcnt = 4'(q.tcnt + 4'h1);
        if (q.tcnt == HOLD_CYC - 4'h1) begin
          d.wdog = 17'h00000;
          d.st = S_CP_ACK;
        end
      end
      S_CP_ACK: begin
        // an ack that fell during the strobe is remembered, not lost
        if (q.ack_got || ack_fall) begin
          d = finish(d, 1'b0); // RQ3
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_NB_LO: begin
        if (!ack_n_s) begin
          if (q.nib_hi) begin
            d.data[7:4] = {busy_s, pe_s, slct_s, error_n_s}; // RQ8
          end else begin
            d.data[3:0] = {busy_s, pe_s, slct_s, error_n_s}; // RQ8
          end
          d.autofd_n = 1'b1; // RQ9
          d.wdog = 17'h00000;
          d.st = S_NB_HI;
        end else if (tmo) begin
          d.autofd_n = 1'b1;
          d = finish(d, 1'b1);
        end
      end
      S_NB_HI: begin
        if (ack_n_s) begin
          d.wdog = 17'h00000;
          if (q.nib_hi) begin
            d = finish(d, 1'b0); // RQ9
          end else begin
            d.nib_hi = 1'b1;
            d.autofd_n = 1'b0; // RQ9
            d.st = S_NB_LO;
          end
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_EP_LO: begin
        if (!busy_s) begin
          if (req_addr_q(q)) begin
            d.slctin_n = 1'b0; // RQ11
          end else begin
            d.autofd_n = 1'b0; // RQ11
          end
          d.wdog = 17'h00000;
          d.st = S_EP_HI; // RQ12
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_EP_HI: begin
        if (busy_s || tmo) begin
          d.autofd_n = 1'b1; // RQ14
          d.slctin_n = 1'b1; // RQ14
          if (q.pd_oe_n) begin
            d.data = pd_s;
          end
          d = finish(d, ~busy_s); // RQ12
        end
      end
      S_EF_LO: begin
        if (!busy_s) begin
          d.strobe_n = 1'b0; // RQ18
          d.wdog = 17'h00000;
          d.st = S_EF_HI;
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_EF_HI: begin
        if (busy_s) begin
          d.strobe_n = 1'b1; // RQ18
          d.wdog = 17'h00000;
          d.st = S_EF_END;
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_EF_END: begin
        if (!busy_s) begin
          d = finish(d, 1'b0); // RQ18
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_ER_REV: begin
        if (!pe_s) begin
          d.wdog = 17'h00000;
          d.st = S_ER_LO; // RQ16
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_ER_LO: begin
        if (!ack_n_s) begin
          d.autofd_n = 1'b1; // RQ20
          d.rsp_cmd = ~busy_s; // RQ21
          d.wdog = 17'h00000;
          d.st = S_ER_HI;
        end else if (tmo) begin
          d = finish(d, 1'b1);
        end
      end
      S_ER_HI: begin
        // data and clock pass one synchroniser, so they stay aligned
        if (ack_n_s) begin
          d.data = pd_s; // RQ20
          d.autofd_n = 1'b0; // RQ20
          d = finish(d, 1'b0);
        end else if (tmo) begin
          d.autofd_n = 1'b0;
          d = finish(d, 1'b1);
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: S_IDLE, tcnt: 4'h0, wdog: 17'h00000, data: 8'h00,
             nib_hi: 1'b0, ack_got: 1'b0, ack_prev: 1'b0, rsp_valid: 1'b0,
             rsp_data: 8'h00, rsp_cmd: 1'b0, rsp_err: 1'b0, ack_event: 1'b0,
             periph_intr: 1'b0, pd_out: 8'h00, pd_oe_n: 1'b1, strobe_n: 1'b1,
             autofd_n: 1'b1, slctin_n: 1'b1, init_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign req_ready = (q.st == S_IDLE);
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign rsp_cmd = q.rsp_cmd & (mode == IEPS_ECP);
  assign rsp_err = q.rsp_err;
  assign paper_empty = pe_s; // RQ4
  assign online = slct_s; // RQ4
  assign fault = ~error_n_s; // RQ4
  assign printer_busy = busy_s;
  assign periph_req = ~error_n_s & (mode == IEPS_ECP);
  assign ack_event = q.ack_event;
  assign periph_intr = q.periph_intr;
  assign pd_out = q.pd_out;
  assign pd_oe_n = q.pd_oe_n;
  assign strobe_n = q.strobe_n;
  assign autofd_n = q.autofd_n;
  assign slctin_n = q.slctin_n;
  assign init_n = q.init_n;

endmodule // ieps_port

`default_nettype wire

// File: hw/ieps_params.svh
// timing and encoding constants for the parallel port signalling block
`ifndef IEPS_PARAMS_SVH
`define IEPS_PARAMS_SVH

`define IEPS_CLK_MHZ 10
`define IEPS_NS2CYC(ns) (((ns) * `IEPS_CLK_MHZ + 999) / 1000)
`define IEPS_SETUP_NS 600
`define IEPS_STB_NS 600
`define IEPS_HOLD_NS 450
`define IEPS_SETUP_CYC `IEPS_NS2CYC(`IEPS_SETUP_NS)
`define IEPS_STB_CYC `IEPS_NS2CYC(`IEPS_STB_NS)
`define IEPS_HOLD_CYC `IEPS_NS2CYC(`IEPS_HOLD_NS)
`define IEPS_TMO_US 10000
`define IEPS_TMO_CYC (`IEPS_TMO_US * `IEPS_CLK_MHZ)
`define IEPS_SYNC_W 13
`define IEPS_SYNC_RST 13'h0000

`endif

// File: hw/ieps_pkg.sv
// types shared by the parallel port signalling block
package ieps_pkg;

  typedef enum logic [1:0] {
    IEPS_COMPAT,
    IEPS_NIBBLE,
    IEPS_EPP,
    IEPS_ECP
  } ieps_mode_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_CP_BUSY,
    S_CP_SETUP,
    S_CP_STB,
    S_CP_HOLD,
    S_CP_ACK,
    S_NB_LO,
    S_NB_HI,
    S_EP_LO,
    S_EP_HI,
    S_EF_LO,
    S_EF_HI,
    S_EF_END,
    S_ER_REV,
    S_ER_LO,
    S_ER_HI
  } ieps_st_t;

endpackage

// File: hw/ieps_sync.sv
// two-flop synchroniser for the peripheral inputs
`timescale 1ns/1ps
`default_nettype none
`include "ieps_params.svh"

module ieps_sync #(
  parameter int WIDTH = `IEPS_SYNC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ieps_sync_st_t;

  ieps_sync_st_t q;
  ieps_sync_st_t d;

  if (WIDTH < 1) begin : g_chk
    $error("ieps_sync: WIDTH must be at least 1");
  end

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {2{WIDTH'(`IEPS_SYNC_RST)}};
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule // ieps_sync

`default_nettype wire

// File: testbench/ieps_port_asserts.sv
// concurrent checks on the pins and status outputs of the parallel port block
`timescale 1ns/1ps
`default_nettype none
module ieps_port_asserts
  import ieps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire ieps_mode_t mode,
  input wire logic init_req,
  input wire logic autofd_req,
  input wire logic select_req,
  input wire logic ecp_reverse,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic paper_empty,
  input wire logic online,
  input wire logic fault,
  input wire logic printer_busy,
  input wire logic periph_req,
  input wire logic ack_event,
  input wire logic periph_intr,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe_n,
  input wire logic strobe_n,
  input wire logic autofd_n,
  input wire logic slctin_n,
  input wire logic init_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic pe,
  input wire logic slct,
  input wire logic error_n
);
  logic [1:0] up_q;
  logic ok;
  // past values reach back into reset for a few cycles after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  assign ok = up_q == 2'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_strobe_width: assert property ($fell(strobe_n) && mode == IEPS_COMPAT |->
    !strobe_n [*6] ##1 strobe_n) else $error("strobe width wrong");
  chk_setup_data: assert property ($fell(strobe_n) && mode == IEPS_COMPAT |->
    !pd_oe_n && $past(pd_out, 4) == pd_out && !$past(busy, 6)) else $error("strobe setup");
  chk_hold_data: assert property ($rose(strobe_n) && mode == IEPS_COMPAT |->
    ($stable(pd_out) && !pd_oe_n) [*5]) else $error("data hold");
  chk_status_map: assert property (ok |-> paper_empty == $past(pe, 2) &&
    online == $past(slct, 2) && fault == !$past(error_n, 2) && printer_busy == $past(busy, 2))
    else $error("status map");
  chk_compat_ctrl: assert property (ok && mode == IEPS_COMPAT && $past(mode) == IEPS_COMPAT |->
    init_n == !$past(init_req) && autofd_n == !$past(autofd_req) &&
    slctin_n == !$past(select_req)) else $error("compat controls");
  chk_nib_active: assert property (ok && mode == IEPS_NIBBLE && $past(mode) == IEPS_NIBBLE |->
    slctin_n && pd_oe_n) else $error("nibble select");
  chk_nib_busy: assert property (ok && mode == IEPS_NIBBLE && $past(mode, 2) == IEPS_NIBBLE &&
    $rose(autofd_n) |-> !$past(ack_n, 2)) else $error("host busy early");
  chk_epp_dir: assert property (mode == IEPS_EPP && !(autofd_n && slctin_n) |->
    pd_oe_n == strobe_n && $stable(strobe_n)) else $error("epp direction");
  chk_epp_one: assert property (mode == IEPS_EPP && $past(mode) == IEPS_EPP |->
    autofd_n || slctin_n) else $error("two epp strobes");
  chk_epp_wait: assert property (mode == IEPS_EPP && ($fell(autofd_n) || $fell(slctin_n)) |->
    !$past(busy, 2)) else $error("epp strobe during wait");
  chk_ecp_fwd: assert property (mode == IEPS_ECP && !strobe_n |->
    !pd_oe_n && $stable(autofd_n) && $stable(pd_out)) else $error("ecp forward");
  chk_ecp_rev: assert property (ok && mode == IEPS_ECP && $past(mode) == IEPS_ECP |->
    init_n == !$past(ecp_reverse) && (init_n || pd_oe_n)) else $error("ecp reverse");
  chk_read_refused: assert property (req_valid && req_ready && mode == IEPS_COMPAT &&
    !req_write |-> ##[1:2] rsp_valid && rsp_err) else $error("compat read taken");
  chk_ack_event: assert property (mode == IEPS_COMPAT && $fell(ack_n) |->
    ##3 ack_event) else $error("ack event missing");
  chk_epp_intr: assert property (mode == IEPS_EPP && $fell(ack_n) |->
    ##3 periph_intr) else $error("epp interrupt missing");
  chk_periph_req: assert property (ok && mode == IEPS_ECP |->
    periph_req == !$past(error_n, 2)) else $error("peripheral request wrong");
  cover property ($fell(strobe_n) && mode == IEPS_COMPAT);
  cover property (rsp_valid && mode == IEPS_NIBBLE);
  cover property (rsp_valid && !init_n && mode == IEPS_ECP);
endmodule // ieps_port_asserts

bind ieps_port ieps_port_asserts u_ieps_port_asserts (.clk, .rst_n, .mode, .init_req,
  .autofd_req, .select_req, .ecp_reverse, .req_valid, .req_ready, .req_write, .rsp_valid,
  .rsp_err, .paper_empty, .online, .fault, .printer_busy, .periph_req, .ack_event,
  .periph_intr, .pd_out, .pd_oe_n, .strobe_n,
  .autofd_n, .slctin_n, .init_n, .ack_n, .busy, .pe, .slct, .error_n);
`default_nettype wire

// File: testbench/ieps_periph.sv
// behavioural peripheral on the far side of the parallel port
`timescale 1ns/1ps
`default_nettype none
module ieps_periph
  import ieps_pkg::*;
(
  input wire logic clk,
  input wire ieps_mode_t mode,
  input wire logic [7:0] tx,
  input wire logic [7:0] dly,
  input wire logic [7:0] pd_out,
  input wire logic strobe_n,
  input wire logic autofd_n,
  input wire logic slctin_n,
  input wire logic init_n,
  output logic [7:0] pd_in,
  output logic [7:0] got,
  output logic got_cmd,
  output logic ack_n,
  output logic busy,
  output logic pe,
  output logic slct,
  output logic error_n
);
  task automatic pause();
    repeat (dly + 1) @(posedge clk);
  endtask
  initial begin
    {ack_n, busy, pe, slct, error_n} = 5'h17;
    pd_in = 8'h3c;
    got = 8'h00;
    got_cmd = 1'b0;
    forever begin
      @(posedge clk);
      if (mode == IEPS_COMPAT && !strobe_n) begin
        busy <= 1'b1;
        @(posedge clk iff strobe_n);
        got <= pd_out;
        pause();
        ack_n <= 1'b0;
        repeat (4) @(posedge clk);
        ack_n <= 1'b1;
        busy <= 1'b0;
      end else if (mode == IEPS_NIBBLE && !autofd_n) begin
        for (int i = 0; i < 2; i++) begin
          @(posedge clk iff !autofd_n);
          pause();
          {busy, pe, slct, error_n} <= tx[i*4 +: 4];
          @(posedge clk);
          ack_n <= 1'b0;
          @(posedge clk iff autofd_n);
          ack_n <= 1'b1;
        end
        {busy, pe, slct, error_n} <= 4'h7;
      end else if (mode == IEPS_EPP && !(autofd_n && slctin_n)) begin
        pd_in <= tx;
        pause();
        got <= pd_out;
        busy <= 1'b1;
        @(posedge clk iff autofd_n && slctin_n);
        busy <= 1'b0;
        pd_in <= ~tx;
        // one-cycle interrupt pulse after each cycle
        ack_n <= 1'b0;
        @(posedge clk);
        ack_n <= 1'b1;
      end else if (mode == IEPS_ECP && !strobe_n) begin
        got_cmd <= !autofd_n;
        pause();
        busy <= 1'b1;
        @(posedge clk iff strobe_n);
        got <= pd_out;
        pause();
        busy <= 1'b0;
      end else if (mode == IEPS_ECP && !init_n) begin
        pe <= 1'b0;
        error_n <= 1'b0;
        pause();
        pd_in <= tx;
        // odd bytes go as commands
        busy <= !tx[0];
        @(posedge clk);
        ack_n <= 1'b0;
        // hold long enough for the host to see it through its synchroniser
        repeat (4) @(posedge clk);
        @(posedge clk iff autofd_n);
        ack_n <= 1'b1;
        @(posedge clk iff !autofd_n);
        pd_in <= ~tx;
        {busy, error_n} <= 2'h1;
        @(posedge clk iff init_n);
        pe <= 1'b1;
      end
    end
  end
endmodule // ieps_periph
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the parallel port signalling block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ieps_pkg::*;
  logic clk, rst_n, init_req, autofd_req, select_req, ecp_reverse, req_valid, req_ready;
  logic req_write, req_addr, rsp_valid, rsp_cmd, rsp_err, paper_empty, online, fault;
  logic printer_busy, periph_req, ack_event, periph_intr, pd_oe_n, strobe_n, autofd_n;
  logic slctin_n, init_n, ack_n, busy, pe, slct, error_n, got_cmd, r_cmd, r_err;
  logic [7:0] req_data, rsp_data, pd_out, pd_in, tx, dly, got, r_data, wd;
  ieps_mode_t mode;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed, k;
  wire logic [7:0] pd_bus = pd_oe_n ? pd_in : pd_out;
  ieps_port #(.TIMEOUT_CYC(50)) u_ieps_port (.clk, .rst_n, .mode, .init_req, .autofd_req,
    .select_req, .ecp_reverse, .req_valid, .req_ready, .req_write, .req_addr, .req_data,
    .rsp_valid, .rsp_data, .rsp_cmd, .rsp_err, .paper_empty, .online, .fault, .printer_busy,
    .periph_req, .ack_event, .periph_intr, .pd_out, .pd_oe_n, .pd_in(pd_bus), .strobe_n,
    .autofd_n, .slctin_n, .init_n, .ack_n, .busy, .pe, .slct, .error_n);
  ieps_periph u_ieps_periph (.clk, .mode, .tx, .dly, .pd_out(pd_bus), .strobe_n, .autofd_n,
    .slctin_n, .init_n, .pd_in, .got, .got_cmd, .ack_n, .busy, .pe, .slct, .error_n);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  function automatic logic exp_cmd(input logic [7:0] b);
    return b[0];
  endfunction
  // one request, held until taken, then the single-cycle answer is captured
  task automatic xfer(input logic w, input logic a, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    for (k = 0; k < 600 && rsp_valid !== 1'b1; k++) @(negedge clk);
    if (k == 600) n_fail++;
    r_data = rsp_data;
    r_cmd = rsp_cmd;
    r_err = rsp_err;
  endtask
  initial begin
    seed = 32'he075;
    rst_n = 1'b0;
    mode = IEPS_COMPAT;
    {init_req, autofd_req, select_req, ecp_reverse, req_valid, req_write, req_addr} = 7'h0;
    {req_data, tx, dly, wd} = 32'h0;
    repeat (20) @(posedge clk);
    chk8({3'h0, pd_oe_n, strobe_n, autofd_n, slctin_n, init_n}, 8'h1f);
    @(negedge clk);
    rst_n = 1'b1;
    for (int t = 0; t < 5; t++) begin
      {init_req, autofd_req, select_req} = 3'($random(seed));
      tx = t ? 8'($random(seed)) : 8'hff;
      dly = {4'h0, 4'($random(seed))};
      xfer(1'b1, 1'b0, tx);
      chk1(r_err, 1'b0);
      chk8(got, tx);
    end
    xfer(1'b0, 1'b0, 8'h00);
    chk1(r_err, 1'b1);
    $display("compat test done");
    {init_req, autofd_req, select_req} = 3'h0;
    mode = IEPS_NIBBLE;
    for (int t = 0; t < 4; t++) begin
      tx = t ? 8'($random(seed)) : 8'ha5;
      dly = {5'h0, 3'($random(seed))};
      xfer(1'b0, 1'b0, 8'h00);
      chk8(r_data, tx);
    end
    xfer(1'b1, 1'b0, 8'h00);
    chk1(r_err, 1'b1);
    $display("nibble test done");
    mode = IEPS_EPP;
    for (int t = 0; t < 4; t++) begin
      tx = 8'($random(seed));
      wd = 8'($random(seed));
      dly = {5'h0, 3'($random(seed))};
      xfer(t[0], t[1], wd);
      chk8(t[0] ? got : r_data, t[0] ? wd : tx);
      chk1(r_err, 1'b0);
    end
    dly = 8'h64;
    xfer(1'b1, 1'b0, wd);
    chk1(r_err, 1'b1);
    wait (busy);
    wait (!busy);
    @(negedge clk);
    $display("epp test done");
    mode = IEPS_ECP;
    dly = 8'h02;
    for (int t = 0; t < 2; t++) begin
      wd = 8'($random(seed));
      xfer(1'b1, t[0], wd);
      chk8(got, wd);
      chk1(got_cmd, t[0]);
    end
    for (int t = 0; t < 3; t++) begin
      tx = 8'($random(seed));
      ecp_reverse = 1'b1;
      xfer(1'b0, 1'b0, 8'h00);
      chk8(r_data, tx);
      chk1(r_cmd, exp_cmd(tx));
      ecp_reverse = 1'b0;
      // let init_n rise so the peripheral closes its reverse phase
      repeat (4) @(negedge clk);
    end
    xfer(1'b0, 1'b0, 8'h00);
    chk1(r_err, 1'b1);
    $display("ecp test done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
